// ---- hdl/pmrs_params.svh ----
// timing counts, reset values and sizes for the power mode reset sequencer
`ifndef PMRS_PARAMS_SVH
`define PMRS_PARAMS_SVH
`define PMRS_MCLK_MHZ 100
`define PMRS_IRC_MHZ 4
`define PMRS_IRC_DIV (`PMRS_MCLK_MHZ / `PMRS_IRC_MHZ)
`define PMRS_IRC_DIV_W 5
`define PMRS_OSC_START_US 60
`define PMRS_OSC_START_CYC (`PMRS_OSC_START_US * `PMRS_MCLK_MHZ)
`define PMRS_FLASH_START_US 100
`define PMRS_FLASH_IRC_CYC (`PMRS_FLASH_START_US * `PMRS_IRC_MHZ)
`define PMRS_FLASH_CNT_W 9
`define PMRS_WAKE_IRC_CYC 4
`define PMRS_RST_IRC_CYC 4
`define PMRS_IRC_CNT_W 3
`define PMRS_RESET_VEC 32'h0000_0000
`define PMRS_NUM_RST_SRC 4
`define PMRS_NUM_EINT 4
`define PMRS_BRAM_WORDS 512
`define PMRS_BRAM_DW 32
`define PMRS_CPU_DIV_W 8
`define PMRS_USB_DIV_W 4
`endif

// ---- hdl/pmrs_pkg.sv ----
// types shared by the power mode reset sequencer
package pmrs_pkg;
  typedef enum logic [2:0] {
    ST_RST, ST_RUN, ST_SLEEP, ST_PD, ST_WK_OSC, ST_WK_CNT, ST_DPD
  } pmrs_state_t;

  typedef struct packed {
    logic pin;
    logic wdt;
    logic por;
    logic brownout_detector;
  } pmrs_rst_src_t;

  typedef struct packed {
    logic pll_en;
    logic pll_conn;
    logic clk_irc;
    logic [7:0] cpu_div;
    logic [3:0] usb_div;
  } pmrs_clk_cfg_t;
endpackage

// ---- hdl/pmrs_sync.sv ----
// two-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module pmrs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] q1_r;
  logic [W-1:0] q2_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q1_r <= RST_VAL;
      q2_r <= RST_VAL;
    end else if (clk_en) begin
      q1_r <= d;
      q2_r <= q1_r;
    end
  end

  assign q = q2_r;
endmodule

// ---- hdl/pmrs_bat_ram.sv ----
// battery-backed ram, array never reset, registered read data
`timescale 1ns/1ps
`include "pmrs_params.svh"
module pmrs_bat_ram #(
  parameter int DEPTH = `PMRS_BRAM_WORDS,
  parameter int DW = `PMRS_BRAM_DW
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic we,
  input wire logic re,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge mclk) begin
    if (clk_en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (clk_en && re) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;
endmodule

// ---- hdl/pmrs_sequencer.sv ----
// power mode and chip reset sequencer top
`timescale 1ns/1ps
`include "pmrs_params.svh"
module pmrs_sequencer #(
  parameter int OSC_START_CYC = `PMRS_OSC_START_CYC,
  parameter int FLASH_IRC_CYC = `PMRS_FLASH_IRC_CYC,
  parameter int NUM_EINT = `PMRS_NUM_EINT,
  parameter int BRAM_WORDS = `PMRS_BRAM_WORDS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rst_pin_n,
  input wire logic wdt_rst,
  input wire logic por_rst,
  input wire logic brownout_detector_lvl1,
  input wire logic brownout_detector_lvl2,
  input wire logic osc_running,
  input wire logic flash_init_done,
  input wire logic sleep_req,
  input wire logic pd_req,
  input wire logic dpd_req,
  input wire logic rtc_alarm,
  input wire logic [NUM_EINT-1:0] eint_wake,
  input wire logic [NUM_EINT-1:0] eint_wake_en,
  input wire logic clk_cfg_wr,
  input wire pmrs_pkg::pmrs_clk_cfg_t clk_cfg,
  input wire logic bram_we,
  input wire logic bram_re,
  input wire logic [$clog2(BRAM_WORDS)-1:0] bram_addr,
  input wire logic [`PMRS_BRAM_DW-1:0] bram_wdata,
  output logic [`PMRS_BRAM_DW-1:0] bram_rdata,
  output logic chip_rst,
  output logic [31:0] fetch_addr,
  output logic cpu_run,
  output logic internal_rc_osc_en,
  output logic cpu_clock_en,
  output logic flash_pwr_en,
  output logic flash_access_ok,
  output logic core_reg_en,
  output pmrs_pkg::pmrs_clk_cfg_t clk_cfg_q,
  output logic brownout_irq,
  output logic brownout_status,
  output logic rtc_alarm_out
);
  localparam int OW = $clog2(OSC_START_CYC + 1);
  localparam int WAKE_CYC = `PMRS_WAKE_IRC_CYC;
  localparam int RST_CYC = `PMRS_RST_IRC_CYC;

  pmrs_pkg::pmrs_state_t state_r;
  pmrs_pkg::pmrs_state_t state_nxt;
  pmrs_pkg::pmrs_rst_src_t src_raw;
  pmrs_pkg::pmrs_rst_src_t src_s;
  logic bod1_s;
  logic rst_req;
  logic wake_any;
  logic irc_tick;
  logic rst_done;
  logic [`PMRS_IRC_DIV_W-1:0] irc_div_r;
  logic [`PMRS_IRC_CNT_W-1:0] irc_cnt_r;
  logic [OW-1:0] osc_cnt_r;
  logic [`PMRS_FLASH_CNT_W-1:0] flash_cnt_r;
  logic chip_rst_r;
  logic [31:0] fetch_addr_r;
  logic cpu_run_r;
  logic irc_en_r;
  logic cpu_clk_en_r;
  logic flash_pwr_r;
  logic flash_ok_r;
  logic core_reg_r;
  pmrs_pkg::pmrs_clk_cfg_t cfg_r;
  logic bod_irq_r;
  logic alarm_r;

  assign src_raw = '{pin: ~rst_pin_n, wdt: wdt_rst, por: por_rst,
                     brownout_detector: brownout_detector_lvl2};

  // sources synchronised, held asserted from reset
  pmrs_sync #(.W(`PMRS_NUM_RST_SRC), .RST_VAL('1)) u_rst_sync (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .d(src_raw),
    .q(src_s)
  );

  pmrs_sync #(.W(1), .RST_VAL(1'b0)) u_bod_sync (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .d(brownout_detector_lvl1),
    .q(bod1_s)
  );

  // only pin and power-on reach unpowered logic in deep power-down
  // stage two and power-on reset merged as one or
  always_comb begin
    if (state_r == pmrs_pkg::ST_DPD) begin
      rst_req = src_s.pin | src_s.por;
    end else begin
      rst_req = src_s.pin | src_s.wdt | src_s.por | src_s.brownout_detector;
    end
  end

  // enabled external interrupts and the rtc alarm wake the chip from sleep and power-down
  assign wake_any = rtc_alarm | (|(eint_wake & eint_wake_en));

  // rc oscillator cycle tick from mclk
  assign irc_tick = irc_en_r && (irc_div_r == `PMRS_IRC_DIV_W'(`PMRS_IRC_DIV - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irc_div_r <= '0;
    end else if (clk_en) begin
      if (!irc_en_r || irc_tick) begin
        irc_div_r <= '0;
      end else begin
        irc_div_r <= irc_div_r + `PMRS_IRC_DIV_W'(1);
      end
    end
  end

  // release needs pin high, oscillator running, count, flash init
  assign rst_done = !rst_req && rst_pin_n && osc_running && flash_init_done
                    && (irc_cnt_r == `PMRS_IRC_CNT_W'(RST_CYC));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pmrs_pkg::ST_RST: begin
        if (rst_done) begin
          state_nxt = pmrs_pkg::ST_RUN;
        end
      end
      pmrs_pkg::ST_RUN: begin
        if (dpd_req) begin
          state_nxt = pmrs_pkg::ST_DPD;
        end else if (pd_req) begin
          state_nxt = pmrs_pkg::ST_PD;
        end else if (sleep_req) begin
          state_nxt = pmrs_pkg::ST_SLEEP;
        end
      end
      pmrs_pkg::ST_SLEEP: begin
        if (wake_any) begin
          state_nxt = pmrs_pkg::ST_WK_CNT;
        end
      end
      pmrs_pkg::ST_PD: begin
        if (wake_any) begin
          state_nxt = pmrs_pkg::ST_WK_OSC;
        end
      end
      pmrs_pkg::ST_WK_OSC: begin
        if (osc_cnt_r == OW'(OSC_START_CYC - 1)) begin
          state_nxt = pmrs_pkg::ST_WK_CNT;
        end
      end
      pmrs_pkg::ST_WK_CNT: begin
        if (irc_tick && irc_cnt_r == `PMRS_IRC_CNT_W'(WAKE_CYC - 1)) begin
          state_nxt = pmrs_pkg::ST_RUN;
        end
      end
      // alarm wake resumes through the full reset path
      pmrs_pkg::ST_DPD: begin
        if (rtc_alarm) begin
          state_nxt = pmrs_pkg::ST_RST;
        end
      end
    endcase
    // power-on after supply loss restarts as a normal start-up
    if (rst_req) begin
      state_nxt = pmrs_pkg::ST_RST;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= pmrs_pkg::ST_RST;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // oscillator start-up counter in mclk cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r == pmrs_pkg::ST_WK_OSC && state_nxt == pmrs_pkg::ST_WK_OSC) begin
        osc_cnt_r <= osc_cnt_r + OW'(1);
      end else begin
        osc_cnt_r <= '0;
      end
    end
  end

  // rc cycle counter for wake and reset hold
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irc_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r != state_nxt || rst_req) begin
        irc_cnt_r <= '0;
      end else if (irc_tick && irc_cnt_r != `PMRS_IRC_CNT_W'(RST_CYC)) begin
        irc_cnt_r <= irc_cnt_r + `PMRS_IRC_CNT_W'(1);
      end
    end
  end

  // flash wake counter, loaded on power-down entry
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flash_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_nxt == pmrs_pkg::ST_PD) begin
        flash_cnt_r <= `PMRS_FLASH_CNT_W'(FLASH_IRC_CYC);
      end else if (irc_tick && flash_cnt_r != '0) begin
        flash_cnt_r <= flash_cnt_r - `PMRS_FLASH_CNT_W'(1);
      end
    end
  end

  // power and clock gating per state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irc_en_r <= 1'b1;
      cpu_clk_en_r <= 1'b0;
      flash_pwr_r <= 1'b1;
      core_reg_r <= 1'b1;
    end else if (clk_en) begin
      irc_en_r <= !(state_nxt inside {pmrs_pkg::ST_PD, pmrs_pkg::ST_DPD});
      cpu_clk_en_r <= (state_nxt == pmrs_pkg::ST_RUN);
      flash_pwr_r <= !(state_nxt inside {pmrs_pkg::ST_PD, pmrs_pkg::ST_DPD});
      // logic regulator off in deep power-down
      core_reg_r <= (state_nxt != pmrs_pkg::ST_DPD);
    end
  end

  // flash access blocked until the counter expires
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flash_ok_r <= 1'b0;
    end else if (clk_en) begin
      flash_ok_r <= flash_pwr_r && (flash_cnt_r == '0)
                    && !(state_nxt inside {pmrs_pkg::ST_RST, pmrs_pkg::ST_PD, pmrs_pkg::ST_DPD});
    end
  end

  // reset output, fetch vector and run enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chip_rst_r <= 1'b1;
      fetch_addr_r <= `PMRS_RESET_VEC;
      cpu_run_r <= 1'b0;
    end else if (clk_en) begin
      chip_rst_r <= (state_nxt == pmrs_pkg::ST_RST) || (state_nxt == pmrs_pkg::ST_DPD);
      if (state_nxt == pmrs_pkg::ST_RST) begin
        fetch_addr_r <= `PMRS_RESET_VEC;
      end
      cpu_run_r <= (state_nxt == pmrs_pkg::ST_RUN);
    end
  end

  // pll and dividers cleared on low-power entry, never restored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_r <= '{pll_en: 1'b0, pll_conn: 1'b0, clk_irc: 1'b1, cpu_div: '0, usb_div: '0};
    end else if (clk_en) begin
      if (state_nxt inside {pmrs_pkg::ST_RST, pmrs_pkg::ST_SLEEP, pmrs_pkg::ST_PD,
                            pmrs_pkg::ST_DPD}) begin
        // rc oscillator chosen after reset and for wake
        cfg_r <= '{pll_en: 1'b0, pll_conn: 1'b0, clk_irc: 1'b1, cpu_div: '0, usb_div: '0};
      end else if (clk_cfg_wr && state_r == pmrs_pkg::ST_RUN) begin
        cfg_r <= clk_cfg;
      end
    end
  end

  // brownout stage one interrupt and status
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bod_irq_r <= 1'b0;
    end else if (clk_en) begin
      bod_irq_r <= bod1_s && core_reg_r;
    end
  end

  // alarm output for external power restore
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarm_r <= 1'b0;
    end else if (clk_en) begin
      alarm_r <= rtc_alarm;
    end
  end

  // battery ram, reachable only while running
  pmrs_bat_ram #(.DEPTH(BRAM_WORDS), .DW(`PMRS_BRAM_DW)) u_bat_ram (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .we(bram_we && cpu_run_r),
    .re(bram_re && cpu_run_r),
    .addr(bram_addr),
    .wdata(bram_wdata),
    .rdata(bram_rdata)
  );

  assign chip_rst = chip_rst_r;
  assign fetch_addr = fetch_addr_r;
  assign cpu_run = cpu_run_r;
  assign internal_rc_osc_en = irc_en_r;
  assign cpu_clock_en = cpu_clk_en_r;
  assign flash_pwr_en = flash_pwr_r;
  assign flash_access_ok = flash_ok_r;
  assign core_reg_en = core_reg_r;
  assign clk_cfg_q = cfg_r;
  assign brownout_irq = bod_irq_r;
  assign brownout_status = bod_irq_r;
  assign rtc_alarm_out = alarm_r;

  // helper counters watched by the checks below
  int unsigned osc_seen;
  int unsigned tick_seen;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_seen <= 0;
      tick_seen <= 0;
    end else if (clk_en) begin
      osc_seen <= (state_nxt == pmrs_pkg::ST_WK_OSC && state_r == pmrs_pkg::ST_WK_OSC)
                  ? osc_seen + 1 : 0;
      tick_seen <= (state_r != pmrs_pkg::ST_WK_CNT || state_nxt != pmrs_pkg::ST_WK_CNT) ? 0
                   : (irc_tick ? tick_seen + 1 : tick_seen);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  pd_power_off_a: assert property (
    $past(clk_en) && state_r == pmrs_pkg::ST_PD |-> !irc_en_r && !flash_pwr_r)
    else $error("power-down left oscillator or flash on");

  osc_startup_a: assert property (
    state_r == pmrs_pkg::ST_WK_CNT && $past(state_r) == pmrs_pkg::ST_WK_OSC
    |-> $past(osc_seen) == OSC_START_CYC - 1)
    else $error("oscillator start-up interval wrong");

  wake_count_a: assert property (
    state_r == pmrs_pkg::ST_RUN && $past(state_r) == pmrs_pkg::ST_WK_CNT
    |-> $past(tick_seen) == WAKE_CYC - 1 && cpu_run)
    else $error("resume after wrong rc cycle count");

  flash_block_a: assert property (
    flash_access_ok |-> flash_pwr_en && $past(flash_cnt_r) == '0)
    else $error("flash access before wake counter expired");

  dpd_regulator_a: assert property (
    $past(clk_en) && state_r == pmrs_pkg::ST_DPD |-> !core_reg_en && chip_rst)
    else $error("regulator on in deep power-down");

  dpd_wake_only_a: assert property (
    clk_en && state_r == pmrs_pkg::ST_DPD && !rtc_alarm && !rst_req
    |=> state_r == pmrs_pkg::ST_DPD)
    else $error("deep power-down left without alarm or reset");

  rst_release_a: assert property (
    $fell(chip_rst) |-> $past(flash_init_done) && $past(osc_running) && $past(rst_pin_n))
    else $error("reset released before conditions held");

  fetch_zero_a: assert property (
    $fell(chip_rst) |-> fetch_addr == `PMRS_RESET_VEC && !cfg_r.pll_en)
    else $error("fetch address not zero at release");

  bod_reset_a: assert property (
    clk_en && src_s.brownout_detector && state_r != pmrs_pkg::ST_DPD |=> chip_rst)
    else $error("stage two brownout did not reset");

  sleep_clear_a: assert property (
    $past(clk_en) && state_r == pmrs_pkg::ST_SLEEP
    |-> !clk_cfg_q.pll_en && clk_cfg_q.cpu_div == '0 && clk_cfg_q.usb_div == '0)
    else $error("pll or divider kept in sleep");

  irc_source_a: assert property (
    chip_rst |-> clk_cfg_q.clk_irc)
    else $error("clock source not rc oscillator in reset");

  pd_wake_c: cover property (
    state_r == pmrs_pkg::ST_WK_CNT ##1 state_r == pmrs_pkg::ST_RUN);
  dpd_wake_c: cover property (
    state_r == pmrs_pkg::ST_DPD && rtc_alarm ##1 state_r == pmrs_pkg::ST_RST);
  rst_release_c: cover property ($fell(chip_rst));
  sleep_wake_c: cover property (
    state_r == pmrs_pkg::ST_SLEEP ##1 state_r == pmrs_pkg::ST_WK_CNT);
endmodule

// ---- verification/pmrs_far_side.sv ----
// far-side model: supply monitors, rc oscillator start-up, flash init
`timescale 1ns/1ps
module pmrs_far_side (
  input wire logic mclk,
  input wire logic [15:0] supply_mv,
  input wire logic rc_en,
  input wire logic flash_pwr,
  input wire logic flash_stall,
  output logic lvl1,
  output logic lvl2,
  output logic por,
  output logic osc_running,
  output logic flash_init_done
);
  logic [2:0] osc_sr = 3'h0;
  logic [2:0] fl_cnt = 3'h0;
  assign lvl1 = supply_mv < 16'hB86;
  assign lvl2 = supply_mv < 16'hA5A && supply_mv >= 16'h3E8;
  assign por = supply_mv < 16'h3E8;
  assign osc_running = osc_sr[2];
  assign flash_init_done = fl_cnt == 3'h4;
  // oscillator needs a few cycles after power, flash init restarts when power drops
  always @(posedge mclk) begin
    osc_sr <= {osc_sr[1:0], rc_en};
    if (!flash_pwr || flash_stall) begin
      fl_cnt <= 3'h0;
    end else if (fl_cnt != 3'h4) begin
      fl_cnt <= fl_cnt + 3'h1;
    end
  end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the power mode reset sequencer
`timescale 1ns/1ps
`include "pmrs_params.svh"
module tb;
  localparam int OSC = 20;
  localparam int FLT = 8;
  localparam int RC_T = 25;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic rst_pin_n = 1'b1, wdt_rst = 1'b0, rtc_alarm = 1'b0, flash_stall = 1'b0;
  logic sleep_req = 1'b0, pd_req = 1'b0, dpd_req = 1'b0, clk_cfg_wr = 1'b0;
  logic bram_we = 1'b0, bram_re = 1'b0;
  logic [8:0] bram_addr = 9'h0;
  logic [31:0] bram_wdata = 32'h0;
  logic [3:0] eint_wake = 4'h0, eint_wake_en = 4'h0;
  logic [15:0] supply_mv = 16'hCE4;
  pmrs_pkg::pmrs_clk_cfg_t clk_cfg = '0;
  pmrs_pkg::pmrs_clk_cfg_t clk_cfg_q;
  logic lvl1, lvl2, por, osc_running, flash_init_done;
  logic [31:0] bram_rdata, fetch_addr;
  logic chip_rst, cpu_run, internal_rc_osc_en, cpu_clock_en, flash_pwr_en;
  logic flash_access_ok, core_reg_en, brownout_irq, brownout_status, rtc_alarm_out;
  logic [31:0] seed = 32'h2FF0;
  int error_cnt = 0;
  int checked = 0;

  always #5 mclk = ~mclk;

  pmrs_far_side far (.mclk(mclk), .supply_mv(supply_mv), .rc_en(internal_rc_osc_en),
    .flash_pwr(flash_pwr_en), .flash_stall(flash_stall), .lvl1(lvl1), .lvl2(lvl2),
    .por(por), .osc_running(osc_running), .flash_init_done(flash_init_done));

  pmrs_sequencer #(.OSC_START_CYC(OSC), .FLASH_IRC_CYC(FLT), .NUM_EINT(4),
    .BRAM_WORDS(512)) DUT (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .rst_pin_n(rst_pin_n), .wdt_rst(wdt_rst), .por_rst(por),
    .brownout_detector_lvl1(lvl1), .brownout_detector_lvl2(lvl2),
    .osc_running(osc_running), .flash_init_done(flash_init_done), .sleep_req(sleep_req),
    .pd_req(pd_req), .dpd_req(dpd_req), .rtc_alarm(rtc_alarm), .eint_wake(eint_wake),
    .eint_wake_en(eint_wake_en), .clk_cfg_wr(clk_cfg_wr), .clk_cfg(clk_cfg),
    .bram_we(bram_we), .bram_re(bram_re), .bram_addr(bram_addr),
    .bram_wdata(bram_wdata), .bram_rdata(bram_rdata), .chip_rst(chip_rst),
    .fetch_addr(fetch_addr), .cpu_run(cpu_run), .internal_rc_osc_en(internal_rc_osc_en),
    .cpu_clock_en(cpu_clock_en), .flash_pwr_en(flash_pwr_en),
    .flash_access_ok(flash_access_ok), .core_reg_en(core_reg_en), .clk_cfg_q(clk_cfg_q),
    .brownout_irq(brownout_irq), .brownout_status(brownout_status),
    .rtc_alarm_out(rtc_alarm_out));

  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
    return seed;
  endfunction

  function automatic pmrs_pkg::pmrs_clk_cfg_t rst_cfg();
    return 15'h1000;
  endfunction

  function automatic int wake_lo(input int m);
    return (m != 0 ? OSC : 0) + 3 * RC_T;
  endfunction

  function automatic int wake_hi(input int m);
    return (m != 0 ? OSC : 0) + 4 * RC_T + 2;
  endfunction

  task automatic close_out();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    checked++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
    end
  endtask

  // sel 0: run resumes, 1: chip reset drops, 2: flash opens
  task automatic wait_sig(input int sel, output int n);
    n = 0;
    while (n < 3000 && !(sel == 0 ? cpu_run === 1'b1 :
        sel == 1 ? chip_rst === 1'b0 : flash_access_ok === 1'b1)) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 3000) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, sel);
    end
  endtask

  task automatic wr_cfg(input pmrs_pkg::pmrs_clk_cfg_t c);
    @(negedge mclk);
    clk_cfg = c;
    clk_cfg_wr = 1'b1;
    @(negedge mclk);
    clk_cfg_wr = 1'b0;
    chk_val(clk_cfg_q, c);
  endtask

  task automatic bram_op(input logic wr, input logic [8:0] a, input logic [31:0] d);
    @(negedge mclk);
    bram_addr = a;
    bram_wdata = d;
    bram_we = wr;
    bram_re = !wr;
    @(negedge mclk);
    bram_we = 1'b0;
    bram_re = 1'b0;
    if (!wr) chk_val(bram_rdata, d);
  endtask

  initial begin
    #400000;
    error_cnt++;
    close_out();
  end

  initial begin
    int n;
    int n2;
    logic [31:0] r;
    logic [31:0] d;
    logic [8:0] a;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    wait_sig(1, n);
    chk_val(fetch_addr, 32'h0);
    chk_val(clk_cfg_q, rst_cfg());
    wait_sig(0, n);
    for (int k = 0; k < 4; k++) begin
      wr_cfg(15'(rnd()));
      @(negedge mclk);
      case (k)
        0: wdt_rst = 1'b1;
        1: rst_pin_n = 1'b0;
        2: supply_mv = 16'hA28;
        default: supply_mv = 16'h1F4;
      endcase
      repeat (3) @(posedge mclk);
      #1 chk_val({chip_rst, cpu_run}, 2'h2);
      repeat (20) @(negedge mclk);
      flash_stall = (k == 3);
      wdt_rst = 1'b0;
      rst_pin_n = 1'b1;
      supply_mv = 16'hCE4;
      if (k == 3) begin
        repeat (300) @(posedge mclk);
        #1 chk_val(chip_rst, 1'b1);
        @(negedge mclk);
        flash_stall = 1'b0;
      end
      wait_sig(1, n);
      chk_rng(n, k == 3 ? 1 : 3 * RC_T + 2, k == 3 ? 40 : 4 * RC_T + 5);
      chk_val(clk_cfg_q, rst_cfg());
      chk_val(fetch_addr, 32'h0);
      wait_sig(0, n);
    end
    @(negedge mclk);
    supply_mv = 16'hB54;
    repeat (4) @(posedge mclk);
    #1 chk_val({brownout_irq, brownout_status, chip_rst}, 3'h6);
    @(negedge mclk);
    supply_mv = 16'hCE4;
    repeat (4) @(posedge mclk);
    #1 chk_val({brownout_irq, brownout_status}, 2'h0);
    // frozen sequencer ignores a sleep request
    @(negedge mclk);
    clk_en = 1'b0;
    sleep_req = 1'b1;
    repeat (5) @(negedge mclk);
    chk_val({cpu_run, cpu_clock_en}, 2'h3);
    sleep_req = 1'b0;
    clk_en = 1'b1;
    for (int m = 0; m < 2; m++) begin
      wr_cfg(15'(rnd()));
      @(negedge mclk);
      sleep_req = (m == 0);
      pd_req = (m == 1);
      @(negedge mclk);
      sleep_req = 1'b0;
      pd_req = 1'b0;
      chk_val({cpu_run, cpu_clock_en, clk_cfg_q.pll_en, clk_cfg_q.pll_conn,
        clk_cfg_q.cpu_div, clk_cfg_q.usb_div}, 32'h0);
      chk_val({internal_rc_osc_en, flash_pwr_en}, m != 0 ? 2'h0 : 2'h3);
      r = rnd();
      eint_wake = 4'h1 << r[1:0];
      repeat (60) @(negedge mclk);
      chk_val(cpu_run, 1'b0);
      if (m != 0) eint_wake_en = eint_wake;
      else rtc_alarm = 1'b1;
      wait_sig(0, n);
      chk_rng(n, wake_lo(m), wake_hi(m));
      chk_val({internal_rc_osc_en, flash_access_ok}, m != 0 ? 2'h2 : 2'h3);
      if (m != 0) begin
        wait_sig(2, n2);
        chk_rng(n + n2, (FLT - 1) * RC_T, (FLT + 1) * RC_T + 15);
      end
      @(negedge mclk);
      eint_wake = 4'h0;
      eint_wake_en = 4'h0;
      rtc_alarm = 1'b0;
      wr_cfg(15'(rnd()));
    end
    r = rnd();
    d = rnd();
    a = r[8:0];
    bram_op(1'b1, a, d);
    for (int j = 0; j < 2; j++) begin
      @(negedge mclk);
      dpd_req = 1'b1;
      @(negedge mclk);
      dpd_req = 1'b0;
      chk_val({core_reg_en, chip_rst, cpu_run}, 3'h2);
      wdt_rst = 1'b1;
      eint_wake_en = 4'hF;
      eint_wake = 4'hF;
      supply_mv = 16'hA28;
      repeat (60) @(negedge mclk);
      chk_val({core_reg_en, cpu_run}, 2'h0);
      wdt_rst = 1'b0;
      eint_wake = 4'h0;
      eint_wake_en = 4'h0;
      supply_mv = j != 0 ? 16'h0 : 16'hCE4;
      rtc_alarm = (j == 0);
      repeat (3) @(negedge mclk);
      chk_val(rtc_alarm_out, j == 0);
      repeat (40) @(negedge mclk);
      supply_mv = 16'hCE4;
      rtc_alarm = 1'b0;
      wait_sig(0, n);
      chk_val(clk_cfg_q, rst_cfg());
      bram_op(1'b0, a, d);
    end
    close_out();
  end
endmodule
